// >>> rtl/dcie_evaluator.v
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dcie_map.vh"

module dcie_evaluator #(
    parameter [`DCIE_TICK_W-1:0] TICK_CYC = `DCIE_TICK_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  chIn,
    input  wire        testReq,
    output reg         permit_ff,
    output reg         faultPresent_ff,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // Address decode shared by write and read paths
    function [`DCIE_SEL_W-1:0] regSel;
        input [`DCIE_ADDR_W-1:0] addr;
        begin
            if (addr == `DCIE_REG_CTRL) begin
                regSel = `DCIE_SEL_CTRL;
            end else if (addr == `DCIE_REG_DISC) begin
                regSel = `DCIE_SEL_DISC;
            end else if (addr == `DCIE_REG_SYNC) begin
                regSel = `DCIE_SEL_SYNC;
            end else if (addr == `DCIE_REG_STAT) begin
                regSel = `DCIE_SEL_STAT;
            end else begin
                regSel = `DCIE_SEL_NONE;
            end
        end
    endfunction

    // Byte-lane merge of a write into an old word
    function [31:0] mergeBytes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  strb;
        integer      i;
        begin
            mergeBytes = oldVal;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
                end
            end
        end
    endfunction

    // Configuration and state registers
    reg  [`DCIE_CTRL_W-1:0]   ctrl_ff;
    reg  [`DCIE_LIM_W-1:0]    discLim_ff;
    reg  [`DCIE_LIM_W-1:0]    syncLim_ff;
    reg  [`DCIE_TICK_W-1:0]   tickCnt_ff;
    reg                       tick_ff;
    reg  [`DCIE_LIM_W-1:0]    syncCnt_ff;
    reg                       syncErr_ff;
    reg                       errLatch_ff;
    reg                       testPend_ff;
    reg                       testReqDly_ff;

    // Bus state
    reg                       awHeld_ff;
    reg  [`DCIE_ADDR_W-1:0]   awAddr_ff;
    reg                       wHeld_ff;
    reg  [31:0]               wData_ff;
    reg  [3:0]                wStrb_ff;

    wire [`DCIE_MODE_W-1:0]   mode;
    wire                      diagEn;
    wire                      testEn;
    wire                      opposite;
    wire                      pairMode;
    wire                      twoPair;
    wire [`DCIE_ST_W*2-1:0]   pairState;
    wire [1:0]                discExp;
    wire [1:0]                pairMonEn;
    wire                      allInactive;
    wire                      syncTiming;
    wire                      anyErr;
    wire                      doAw;
    wire                      doW;
    wire                      doWr;
    wire                      doAr;
    wire [`DCIE_SEL_W-1:0]    wrSel;
    wire [`DCIE_SEL_W-1:0]    rdSel;
    wire [31:0]               ctrlNew;
    // Write data merged into the limit registers
    wire [31:0]               discNew;
    wire [31:0]               syncNew;
    wire                      testEnRise;
    wire                      testReqRise;
    reg                       rawPermit;
    reg  [31:0]               rdMux;
    reg                       nxt_awHeld;
    reg                       nxt_wHeld;
    reg                       nxt_bvalid;
    reg                       nxt_rvalid;

    assign mode     = ctrl_ff[`DCIE_CTRL_MODE];
    assign diagEn   = ctrl_ff[`DCIE_CTRL_DIAG];
    assign testEn   = ctrl_ff[`DCIE_CTRL_TEST];
    assign opposite = (mode == `DCIE_MODE_CP) | (mode == `DCIE_MODE_CP2);
    assign pairMode = (mode == `DCIE_MODE_EQ) | (mode == `DCIE_MODE_CP);
    assign twoPair  = (mode == `DCIE_MODE_EQ2) | (mode == `DCIE_MODE_CP2);

    // Discrepancy checking only on the first pair in single-pair modes
    assign pairMonEn = {1'b0, pairMode};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : genPair
            dcie_pair_mon uPair (
                .clk        (clk),
                .rst_n      (rst_n),
                .chA        (chIn[2*g]),
                .chB        (chIn[2*g+1]),
                .opposite   (opposite),
                .monEn      (pairMonEn[g]),
                .limit      (discLim_ff),
                .tick       (tick_ff),
                .pairState  (pairState[g*`DCIE_ST_W +: `DCIE_ST_W]),
                .expired_ff (discExp[g])
            );
        end
    endgenerate

    // Output truth table per input type
    always @* begin
        case (mode)
            `DCIE_MODE_SINGLE: rawPermit = chIn[0];
            `DCIE_MODE_EQ:     rawPermit = chIn[0] & chIn[1];
            `DCIE_MODE_CP:     rawPermit = chIn[0] & ~chIn[1];
            `DCIE_MODE_EQ2:    rawPermit = &chIn;
            `DCIE_MODE_CP2:    rawPermit = chIn[0] & ~chIn[1] &
                                           chIn[2] & ~chIn[3];
            default:           rawPermit = 1'b0;
        endcase
    end

    // Rest state used to release a latched error
    assign allInactive = (mode == `DCIE_MODE_SINGLE) ? ~chIn[0] :
                         twoPair ?
                         ((pairState[1:0] == `DCIE_ST_INACT) &
                          (pairState[3:2] == `DCIE_ST_INACT)) :
                         (pairState[1:0] == `DCIE_ST_INACT);

    // Pair-to-pair skew timer
    assign syncTiming = twoPair & (syncLim_ff != `DCIE_LIM_RST) &
                        (pairState[1:0] != pairState[3:2]);

    assign anyErr = (|discExp) | syncErr_ff;

    // Fixed-period timebase
    always @(posedge clk) begin
        if (!rst_n) begin
            tickCnt_ff <= {`DCIE_TICK_W{1'b0}};
            tick_ff    <= 1'b0;
        end else if (tickCnt_ff == TICK_CYC - 1'b1) begin
            tickCnt_ff <= {`DCIE_TICK_W{1'b0}};
            tick_ff    <= 1'b1;
        end else begin
            tickCnt_ff <= tickCnt_ff + 1'b1;
            tick_ff    <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            syncCnt_ff <= `DCIE_LIM_RST;
            syncErr_ff <= 1'b0;
        end else if (!syncTiming) begin
            syncCnt_ff <= `DCIE_LIM_RST;
            syncErr_ff <= 1'b0;
        end else begin
            if (tick_ff && syncCnt_ff != syncLim_ff) begin
                syncCnt_ff <= syncCnt_ff + 1'b1;
            end
            syncErr_ff <= (syncCnt_ff == syncLim_ff);
        end
    end

    // Function test request handling
    assign ctrlNew     = mergeBytes({{(32-`DCIE_CTRL_W){1'b0}}, ctrl_ff},
                                    wData_ff, wStrb_ff);
    assign testEnRise  = doWr & (wrSel == `DCIE_SEL_CTRL) &
                         ctrlNew[`DCIE_CTRL_TEST] & ~testEn;
    assign testReqRise = testEn & testReq & ~testReqDly_ff;

    always @(posedge clk) begin
        if (!rst_n) begin
            testReqDly_ff <= 1'b0;
            testPend_ff   <= 1'b0;
        end else begin
            testReqDly_ff <= testReq;
            if (testEnRise || testReqRise) begin
                testPend_ff <= 1'b1;
            end else if (allInactive || !testEn) begin
                testPend_ff <= 1'b0;
            end
        end
    end

    // Error latch, permit and fault outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            errLatch_ff     <= 1'b0;
            permit_ff       <= 1'b0;
            faultPresent_ff <= 1'b0;
        end else begin
            if (anyErr) begin
                errLatch_ff <= 1'b1;
            end else if (allInactive) begin
                errLatch_ff <= 1'b0;
            end
            permit_ff <= rawPermit & ~anyErr & ~errLatch_ff &
                         ~testPend_ff;
            faultPresent_ff <= diagEn & (anyErr | errLatch_ff);
        end
    end

    // AXI4-Lite write path
    assign doAw  = s_axi_awvalid & s_axi_awready;
    assign doW   = s_axi_wvalid & s_axi_wready;
    assign doWr  = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
    assign wrSel = regSel(awAddr_ff);

    always @* begin
        nxt_awHeld = (awHeld_ff | doAw) & ~doWr;
        nxt_wHeld  = (wHeld_ff | doW) & ~doWr;
        nxt_bvalid = doWr | (s_axi_bvalid & ~s_axi_bready);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            awHeld_ff     <= 1'b0;
            awAddr_ff     <= {`DCIE_ADDR_W{1'b0}};
            wHeld_ff      <= 1'b0;
            wData_ff      <= 32'h0000_0000;
            wStrb_ff      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DCIE_RESP_OKAY;
        end else begin
            awHeld_ff     <= nxt_awHeld;
            wHeld_ff      <= nxt_wHeld;
            s_axi_bvalid  <= nxt_bvalid;
            s_axi_awready <= ~nxt_awHeld & ~nxt_bvalid;
            s_axi_wready  <= ~nxt_wHeld & ~nxt_bvalid;
            if (doAw) begin
                awAddr_ff <= {s_axi_awaddr[`DCIE_ADDR_W-1:2], 2'b00};
            end
            if (doW) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (doWr) begin
                s_axi_bresp <= (wrSel == `DCIE_SEL_NONE) ?
                               `DCIE_RESP_SLVERR : `DCIE_RESP_OKAY;
            end
        end
    end

    // Limit words after byte-lane merge, upper half dropped
    assign discNew = mergeBytes({16'h0000, discLim_ff}, wData_ff, wStrb_ff);
    assign syncNew = mergeBytes({16'h0000, syncLim_ff}, wData_ff, wStrb_ff);

    // Configuration registers
    always @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff    <= `DCIE_CTRL_RST;
            discLim_ff <= `DCIE_LIM_RST;
            syncLim_ff <= `DCIE_LIM_RST;
        end else if (doWr) begin
            if (wrSel == `DCIE_SEL_CTRL) begin
                ctrl_ff <= ctrlNew[`DCIE_CTRL_W-1:0];
            end else if (wrSel == `DCIE_SEL_DISC) begin
                discLim_ff <= discNew[`DCIE_LIM_W-1:0];
            end else if (wrSel == `DCIE_SEL_SYNC) begin
                syncLim_ff <= syncNew[`DCIE_LIM_W-1:0];
            end
        end
    end

    // AXI4-Lite read path
    assign doAr  = s_axi_arvalid & s_axi_arready;
    assign rdSel = regSel({s_axi_araddr[`DCIE_ADDR_W-1:2], 2'b00});

    always @* begin
        if (rdSel == `DCIE_SEL_CTRL) begin
            rdMux = {{(32-`DCIE_CTRL_W){1'b0}}, ctrl_ff};
        end else if (rdSel == `DCIE_SEL_DISC) begin
            rdMux = {16'h0000, discLim_ff};
        end else if (rdSel == `DCIE_SEL_SYNC) begin
            rdMux = {16'h0000, syncLim_ff};
        end else if (rdSel == `DCIE_SEL_STAT) begin
            rdMux = {18'h00000, chIn, pairState, testPend_ff, errLatch_ff,
                     syncErr_ff, discExp, permit_ff};
        end else begin
            rdMux = 32'h0000_0000;
        end
        nxt_rvalid = doAr | (s_axi_rvalid & ~s_axi_rready);
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DCIE_RESP_OKAY;
        end else begin
            s_axi_rvalid  <= nxt_rvalid;
            s_axi_arready <= ~nxt_rvalid;
            if (doAr) begin
                s_axi_rdata <= rdMux;
                s_axi_rresp <= (rdSel == `DCIE_SEL_NONE) ?
                               `DCIE_RESP_SLVERR : `DCIE_RESP_OKAY;
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/dcie_map.vh
`ifndef DCIE_MAP_VH
`define DCIE_MAP_VH

`define DCIE_CLK_PERIOD_NS  5
`define DCIE_TICK_NS        1000000
`define DCIE_TICK_CYC       18'h30d40
`define DCIE_TICK_W         18

`define DCIE_ADDR_W         4
`define DCIE_REG_CTRL       4'h0
`define DCIE_REG_DISC       4'h4
`define DCIE_REG_SYNC       4'h8
`define DCIE_REG_STAT       4'hc

`define DCIE_SEL_W          3
`define DCIE_SEL_NONE       3'h0
`define DCIE_SEL_CTRL       3'h1
`define DCIE_SEL_DISC       3'h2
`define DCIE_SEL_SYNC       3'h3
`define DCIE_SEL_STAT       3'h4

`define DCIE_CTRL_W         6
`define DCIE_CTRL_RST       6'h00
`define DCIE_CTRL_MODE      2:0
`define DCIE_CTRL_DIAG      4
`define DCIE_CTRL_TEST      5

`define DCIE_LIM_W          16
`define DCIE_LIM_RST        16'h0000

`define DCIE_MODE_W         3
`define DCIE_MODE_SINGLE    3'h0
`define DCIE_MODE_EQ        3'h1
`define DCIE_MODE_CP        3'h2
`define DCIE_MODE_EQ2       3'h3
`define DCIE_MODE_CP2       3'h4

`define DCIE_ST_W           2
`define DCIE_ST_INACT       2'h0
`define DCIE_ST_ACT         2'h1
`define DCIE_ST_DISC        2'h2

`define DCIE_RESP_OKAY      2'h0
`define DCIE_RESP_SLVERR    2'h2

`endif

// >>> rtl/dcie_pair_mon.v
`timescale 1ns/1ps
`default_nettype none
`include "dcie_map.vh"

module dcie_pair_mon (
    input  wire                     clk,
    input  wire                     rst_n,
    input  wire                     chA,
    input  wire                     chB,
    input  wire                     opposite,
    input  wire                     monEn,
    input  wire [`DCIE_LIM_W-1:0]   limit,
    input  wire                     tick,
    output wire [`DCIE_ST_W-1:0]    pairState,
    output reg                      expired_ff
);

    reg  [`DCIE_LIM_W-1:0] cnt_ff;
    wire                   chBNorm;
    wire                   timing;

    // Normalise the second channel so both read high when active
    assign chBNorm   = opposite ? ~chB : chB;
    assign pairState = (chA & chBNorm)   ? `DCIE_ST_ACT :
                       (~chA & ~chBNorm) ? `DCIE_ST_INACT :
                                           `DCIE_ST_DISC;

    // Timer runs while the pair is split, either direction
    assign timing = monEn & (limit != `DCIE_LIM_RST) &
                    (pairState == `DCIE_ST_DISC);

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff     <= `DCIE_LIM_RST;
            expired_ff <= 1'b0;
        end else if (!timing) begin
            cnt_ff     <= `DCIE_LIM_RST;
            expired_ff <= 1'b0;
        end else begin
            if (tick && cnt_ff != limit) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            expired_ff <= (cnt_ff == limit);
        end
    end

endmodule

`default_nettype wire

// >>> tb/dcie_eval_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcie_map.vh"

module dcie_eval_sva #(
    parameter [`DCIE_TICK_W-1:0] TICK_CYC = `DCIE_TICK_CYC
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] chIn,
    input wire logic       permit_ff,
    input wire logic       faultPresent_ff,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    aw_accept_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready high after address taken");
    ar_accept_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("arready high after address taken");
    write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles later");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle later");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("read answer dropped");
    permit_ch1_a: assert property (permit_ff |-> $past(chIn[0]))
        else $error("permit without first channel closed");
    fault_block_a: assert property (faultPresent_ff |-> !permit_ff)
        else $error("permit while fault latched");

    write_done_c: cover property (s_axi_bvalid && s_axi_bready);
    permit_up_c: cover property ($rose(permit_ff));
    fault_up_c: cover property ($rose(faultPresent_ff));
endmodule

bind dcie_evaluator dcie_eval_sva #(.TICK_CYC(TICK_CYC)) u_sva (
    .clk, .rst_n, .chIn, .permit_ff, .faultPresent_ff, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// >>> tb/dcie_contacts.sv
`timescale 1ns/1ps
`default_nettype none

module dcie_contacts (
    input  wire logic       clk,
    input  wire logic [3:0] tgt,
    input  wire logic [5:0] lagB,
    input  wire logic [5:0] lagP,
    output logic      [3:0] chIn
);
    // Second contact of a pair and the whole second pair follow the actuator late
    logic [3:0] hist_ff [0:63];

    always @(posedge clk) begin
        hist_ff[0] <= tgt;
        for (int i = 1; i < 64; i++) hist_ff[i] <= hist_ff[i-1];
    end
    always_comb begin
        chIn[0] = hist_ff[0][0];
        chIn[1] = hist_ff[lagB][1];
        chIn[2] = hist_ff[lagP][2];
        chIn[3] = hist_ff[lagP + lagB][3];
    end
endmodule

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcie_map.vh"

module testbench;
    logic        clk, rst_n, testReq, permit, fault;
    logic [3:0]  tgt, chIn, s_axi_awaddr, s_axi_araddr;
    logic [5:0]  lagB, lagP;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    int          errors, totalChecks, m, p;

    dcie_evaluator #(.TICK_CYC(18'h4)) u_dut (
        .clk, .rst_n, .chIn, .testReq, .permit_ff(permit), .faultPresent_ff(fault),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    dcie_contacts u_contacts (.clk, .tgt, .lagB, .lagP, .chIn);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic testDone;
        if (errors == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(n, 3);
        check(s_axi_bresp, er);
    endtask

    task automatic axiRead(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(n, 2);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    // Command the contacts, with lag of second channel and second pair, then wait
    task automatic setIn(input logic [3:0] t, input logic [5:0] b, input logic [5:0] q, int w);
        tgt  <= t;
        lagB <= b;
        lagP <= q;
        repeat (w) @(posedge clk);
    endtask

    task automatic expectOut(input logic pe, input logic fe);
        check(permit, pe);
        check(fault, fe);
    endtask

    function automatic logic expPermit(input int md, input logic [3:0] c);
        case (md)
            0: return c[0];
            1: return c[1:0] == 2'b11;
            2: return c[1:0] == 2'b01;
            3: return c == 4'hf;
            4: return c == 4'h5;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] expState(input logic inv, input logic [1:0] c);
        logic [1:0] q;
        q = {c[1] ^ inv, c[0]};
        if (q == 2'b00) return `DCIE_ST_INACT;
        if (q == 2'b11) return `DCIE_ST_ACT;
        return `DCIE_ST_DISC;
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        testDone;
    end

    initial begin
        {rst_n, testReq, tgt, lagB, lagP, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wdata = '0;
        errors = 0;
        totalChecks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (m = 0; m < 4; m++) begin
            axiRead(4 * m);
            check(rd, 0);
        end
        axiWrite(4'h2, 32'h1f, `DCIE_RESP_OKAY);
        axiRead(4'h2);
        check(rr, `DCIE_RESP_OKAY);
        check(rd, 32'h1f);
        axiWrite(`DCIE_REG_STAT, 32'hffff, `DCIE_RESP_OKAY);
        axiRead(`DCIE_REG_STAT);
        check(rd, 0);
        for (m = 0; m < 6; m++) begin
            axiWrite(`DCIE_REG_CTRL, m, `DCIE_RESP_OKAY);
            for (p = 0; p < 16; p++) begin
                setIn(p[3:0], 0, 0, 4);
                check(permit, expPermit(m, p[3:0]));
                if (m == 1 || m == 2) begin
                    axiRead(`DCIE_REG_STAT);
                    check(rd[7:6], expState(m == 2, p[1:0]));
                end
            end
        end
        // Equivalent pair, discrepancy limit two ticks, fault output on
        axiWrite(`DCIE_REG_DISC, 32'h2, `DCIE_RESP_OKAY);
        axiWrite(`DCIE_REG_CTRL, 32'h11, `DCIE_RESP_OKAY);
        setIn(4'h0, 0, 0, 6);
        setIn(4'h3, 2, 0, 20);
        expectOut(1, 0);
        setIn(4'h0, 2, 0, 20);
        expectOut(0, 0);
        setIn(4'h3, 0, 0, 20);
        setIn(4'h2, 0, 0, 20);
        expectOut(0, 1);
        setIn(4'h3, 0, 0, 6);
        expectOut(0, 1);
        setIn(4'h0, 0, 0, 6);
        expectOut(0, 0);
        setIn(4'h1, 0, 0, 20);
        expectOut(0, 1);
        setIn(4'h0, 0, 0, 6);
        setIn(4'h3, 0, 0, 6);
        expectOut(1, 0);
        axiWrite(`DCIE_REG_CTRL, 32'h1, `DCIE_RESP_OKAY);
        setIn(4'h1, 0, 0, 20);
        expectOut(0, 0);
        axiRead(`DCIE_REG_STAT);
        check(rd[4], 1);
        setIn(4'h0, 0, 0, 6);
        axiWrite(`DCIE_REG_CTRL, 32'h12, `DCIE_RESP_OKAY);
        setIn(4'h2, 0, 0, 6);
        setIn(4'h3, 0, 0, 20);
        expectOut(0, 1);
        setIn(4'h2, 0, 0, 6);
        axiWrite(`DCIE_REG_CTRL, 32'h10, `DCIE_RESP_OKAY);
        setIn(4'h1, 0, 0, 30);
        expectOut(1, 0);
        axiWrite(`DCIE_REG_DISC, 32'h0, `DCIE_RESP_OKAY);
        axiWrite(`DCIE_REG_CTRL, 32'h11, `DCIE_RESP_OKAY);
        setIn(4'h0, 0, 0, 6);
        setIn(4'h1, 0, 0, 30);
        expectOut(0, 0);
        setIn(4'h3, 0, 0, 6);
        expectOut(1, 0);
        // Two equivalent pairs, synchronization limit two ticks
        axiWrite(`DCIE_REG_SYNC, 32'h2, `DCIE_RESP_OKAY);
        axiWrite(`DCIE_REG_CTRL, 32'h13, `DCIE_RESP_OKAY);
        setIn(4'h0, 0, 0, 6);
        setIn(4'hf, 0, 2, 20);
        expectOut(1, 0);
        setIn(4'h0, 0, 2, 20);
        setIn(4'h3, 0, 0, 20);
        expectOut(0, 1);
        setIn(4'h0, 0, 0, 6);
        expectOut(0, 0);
        axiWrite(`DCIE_REG_SYNC, 32'h0, `DCIE_RESP_OKAY);
        setIn(4'h3, 0, 0, 30);
        expectOut(0, 0);
        axiWrite(`DCIE_REG_CTRL, 32'h1, `DCIE_RESP_OKAY);
        setIn(4'h3, 0, 0, 6);
        axiWrite(`DCIE_REG_CTRL, 32'h21, `DCIE_RESP_OKAY);
        setIn(4'h3, 0, 0, 4);
        check(permit, 0);
        setIn(4'h0, 0, 0, 6);
        setIn(4'h3, 0, 0, 6);
        check(permit, 1);
        testReq <= 1'b1;
        setIn(4'h3, 0, 0, 6);
        check(permit, 0);
        testReq <= 1'b0;
        setIn(4'h0, 0, 0, 6);
        setIn(4'h3, 0, 0, 6);
        check(permit, 1);
        testDone;
    end
endmodule

`default_nettype wire
